// [core/asf_pkg.sv]
// shared constants and carriers of the alu and flag register
`default_nettype none
package asf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // flag register layout
    localparam int unsigned BIT_CARRY   = 0;            // carry / borrow
    localparam int unsigned BIT_NIBBLE  = 1;            // nibble carry / borrow
    localparam int unsigned BIT_ZERO    = 2;            // zero result
    localparam int unsigned BIT_SIGNED  = 3;            // signed range exceeded
    localparam int unsigned BIT_PTR0_LO = 4;            // pointer zero step mode
    localparam int unsigned BIT_PTR1_LO = 6;            // pointer one step mode
    localparam logic [7:0]  FLAG_RESET  = 8'hf0;        // step modes hold, flags clear

    ////////////////////////////////////////////////////////////////////////////
    // register bus map and answers
    localparam logic [31:0] OFS_FLAG    = 32'h0000_0000; // flag register, read/write
    localparam logic [31:0] OFS_RESULT  = 32'h0000_0004; // last result, read only
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // operations, operand sources and pointer step actions
    typedef enum logic [4:0] {
        OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR, OP_XOR, OP_COM,
        OP_INC, OP_DEC, OP_RRC, OP_RLC, OP_SWAP, OP_CLR, OP_MOV, OP_BCLR, OP_BSET
    } asf_op_t;

    typedef enum logic [1:0] {SRC_ACC, SRC_FILE, SRC_IMM} asf_src_t;

    typedef enum logic [1:0] {STEP_DEC, STEP_INC, STEP_HOLD} asf_step_t;

    // one instruction from the decoder
    typedef struct packed {
        logic       valid;      // execute this cycle
        asf_op_t    op;         // operation
        asf_src_t   src;        // second / single operand source
        logic [7:0] acc;        // accumulator_reg value
        logic [7:0] file;       // addressed file register value
        logic [7:0] imm;        // immediate from the instruction word
        logic [2:0] bitSel;     // bit number for bit clear / set
        logic       destFlag;   // destination is the flag register
    } asf_req_t;

    // answer to the decoder
    typedef struct packed {
        logic       done;       // result valid, one cycle
        logic [7:0] result;     // 8-bit result
        logic [7:0] flags;      // alu_flag_register contents
        asf_step_t  ptr0Step;   // pointer_zero post-access action
        asf_step_t  ptr1Step;   // pointer_one post-access action
    } asf_rsp_t;

endpackage
`default_nettype wire

// [core/asf_alu_status_flag_logic.sv]
// How it works
// - alu runs one- or two-operand arithmetic or logic op the instruction selects
// - single operand comes from accumulator_reg or the addressed file register
// - two-operand ops use accumulator plus file register or 8-bit immediate
// - flag register holds result flags and both pointer step mode fields
// - any instruction may write the flag register; unblocked bits take its value
// - zero, nibble carry and carry bits ignore the write when the op sets them
// - clear-file on the flag register gives 0000u1uu
// - bit clear, bit set, nibble swap and store leave all flags alone
// - in subtraction carry and nibble carry are borrows of inverted polarity
// - signed_range_exceeded sets when signed result leaves -128..+127
// - step mode 00 decrements, 01 increments, 1x holds the pointer
// - nibble_carry_flag sets on carry out of bit 3 in an addition
// - subtraction adds the two's complement; rotates load carry with bit shifted out
// - flag layout: ptr1 mode 7-6, ptr0 mode 5-4, overflow 3, zero 2, nibble 1, carry 0
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module asf_alu_status_flag_logic (
    input  wire logic            clk,            // 100 MHz core clock
    input  wire logic            resetn,         // async reset, active low
    input  wire asf_pkg::asf_req_t req,          // instruction from decoder
    output asf_pkg::asf_rsp_t    rsp,            // result, flags, step modes
    input  wire logic [31:0]     s_axi_awaddr,   // write address
    input  wire logic            s_axi_awvalid,  // write address valid
    output logic                 s_axi_awready,  // write address ready
    input  wire logic [31:0]     s_axi_wdata,    // write data
    input  wire logic [3:0]      s_axi_wstrb,    // write byte enables
    input  wire logic            s_axi_wvalid,   // write data valid
    output logic                 s_axi_wready,   // write data ready
    output logic [1:0]           s_axi_bresp,    // write response
    output logic                 s_axi_bvalid,   // write response valid
    input  wire logic            s_axi_bready,   // write response ready
    input  wire logic [31:0]     s_axi_araddr,   // read address
    input  wire logic            s_axi_arvalid,  // read address valid
    output logic                 s_axi_arready,  // read address ready
    output logic [31:0]          s_axi_rdata,    // read data
    output logic [1:0]           s_axi_rresp,    // read response
    output logic                 s_axi_rvalid,   // read data valid
    input  wire logic            s_axi_rready    // read data ready
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]          flags_q, flags_d;
    logic [7:0]          result_q, result_d;
    logic                done_q, done_d;
    asf_pkg::asf_step_t  ptr0_q, ptr0_d, ptr1_q, ptr1_d;
    logic                awrdy_q, awrdy_d, bvalid_q, bvalid_d;
    logic [1:0]          bresp_q, bresp_d, rresp_q, rresp_d;
    logic                arrdy_q, arrdy_d, rvalid_q, rvalid_d;
    logic [31:0]         rdata_q, rdata_d;

    // datapath intermediates
    logic [7:0] opnd, addX, addY, res, base, affect, logicFlags;
    logic       cin, isArith, busWr;
    logic [8:0] sum;
    logic [4:0] nib;

    ////////////////////////////////////////////////////////////////////////////
    // step mode decode for one pointer
    function automatic asf_pkg::asf_step_t stepOf(input logic [1:0] code);
        if (code[1]) begin
            return asf_pkg::STEP_HOLD;
        end
        return code[0] ? asf_pkg::STEP_INC : asf_pkg::STEP_DEC;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // operand select and adder
    always_comb begin
        // accumulator or file for single ops, file or immediate as second operand
        case (req.src)
            asf_pkg::SRC_FILE: opnd = req.file;
            asf_pkg::SRC_IMM:  opnd = req.imm;
            default:           opnd = req.acc;
        endcase
        addX    = req.acc;
        addY    = opnd;
        cin     = 1'b0;
        isArith = 1'b1;
        case (req.op)
            asf_pkg::OP_ADDC: cin = flags_q[asf_pkg::BIT_CARRY];
            // subtract accumulator from operand by adding its two's complement
            asf_pkg::OP_SUB: begin
                addX = opnd;
                addY = ~req.acc;
                cin  = 1'b1;
            end
            asf_pkg::OP_SUBB: begin
                addX = opnd;
                addY = ~req.acc;
                cin  = flags_q[asf_pkg::BIT_CARRY];
            end
            asf_pkg::OP_INC: begin
                addX = opnd;
                addY = 8'h00;
                cin  = 1'b1;
            end
            asf_pkg::OP_DEC: begin
                addX = opnd;
                addY = 8'hff;
            end
            asf_pkg::OP_ADD: cin = 1'b0;
            default: isArith = 1'b0;
        endcase
        sum = {1'b0, addX} + {1'b0, addY} + {8'h00, cin};
        nib = {1'b0, addX[3:0]} + {1'b0, addY[3:0]} + {4'h0, cin};
    end

    ////////////////////////////////////////////////////////////////////////////
    // result and the flag bits each operation produces
    always_comb begin
        res        = sum[7:0];
        affect     = 8'h00;
        logicFlags = flags_q;
        case (req.op)
            asf_pkg::OP_AND:  res = req.acc & opnd;
            asf_pkg::OP_IOR:  res = req.acc | opnd;
            asf_pkg::OP_XOR:  res = req.acc ^ opnd;
            asf_pkg::OP_COM:  res = ~opnd;
            asf_pkg::OP_RRC:  res = {flags_q[asf_pkg::BIT_CARRY], opnd[7:1]};
            asf_pkg::OP_RLC:  res = {opnd[6:0], flags_q[asf_pkg::BIT_CARRY]};
            asf_pkg::OP_SWAP: res = {opnd[3:0], opnd[7:4]};
            asf_pkg::OP_CLR:  res = 8'h00;
            asf_pkg::OP_MOV:  res = req.acc;
            asf_pkg::OP_BCLR: res = opnd & ~(8'h01 << req.bitSel);
            asf_pkg::OP_BSET: res = opnd | (8'h01 << req.bitSel);
            default:          res = sum[7:0];
        endcase
        case (req.op)
            asf_pkg::OP_AND, asf_pkg::OP_IOR, asf_pkg::OP_XOR, asf_pkg::OP_COM,
            asf_pkg::OP_CLR:
                affect[asf_pkg::BIT_ZERO] = 1'b1;
            asf_pkg::OP_RRC, asf_pkg::OP_RLC:
                affect[asf_pkg::BIT_CARRY] = 1'b1;
            asf_pkg::OP_SWAP, asf_pkg::OP_MOV, asf_pkg::OP_BCLR, asf_pkg::OP_BSET:
                affect = 8'h00;
            default:
                affect = isArith ? 8'h0f : 8'h00;
        endcase
        // carry and nibble carry come straight from the adder; borrow = not carry
        logicFlags[asf_pkg::BIT_CARRY]  = sum[8];
        logicFlags[asf_pkg::BIT_NIBBLE] = nib[4];
        logicFlags[asf_pkg::BIT_ZERO]   = (res == 8'h00);
        // sign change with like-signed inputs means range exceeded
        logicFlags[asf_pkg::BIT_SIGNED] = (addX[7] == addY[7]) && (sum[7] != addX[7]);
        if (req.op == asf_pkg::OP_RRC) begin
            logicFlags[asf_pkg::BIT_CARRY] = opnd[0];
        end else if (req.op == asf_pkg::OP_RLC) begin
            logicFlags[asf_pkg::BIT_CARRY] = opnd[7];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag register next value: bus, then instruction write, then flag logic
    always_comb begin
        busWr = awrdy_q && s_axi_awaddr[7:0] == asf_pkg::OFS_FLAG[7:0]
                && s_axi_awaddr[31:8] == 24'h00_0000 && s_axi_wstrb[0];
        base  = busWr ? s_axi_wdata[7:0] : flags_q;
        flags_d  = base;
        result_d = result_q;
        done_d   = req.valid;
        if (req.valid) begin
            result_d = res;
            if (req.destFlag) begin
                flags_d = res;
                // a flag-producing op keeps its data out of the status nibble
                if (affect != 8'h00) flags_d[3:0] = base[3:0];
            end
            // flag logic wins on the bits the op produces
            flags_d = (flags_d & ~affect) | (logicFlags & affect);
        end
        ptr0_d = stepOf(flags_d[asf_pkg::BIT_PTR0_LO +: 2]);
        ptr1_d = stepOf(flags_d[asf_pkg::BIT_PTR1_LO +: 2]);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_q  <= asf_pkg::FLAG_RESET;
            result_q <= 8'h00;
            done_q   <= 1'b0;
            ptr0_q   <= asf_pkg::STEP_HOLD;
            ptr1_q   <= asf_pkg::STEP_HOLD;
        end else begin
            flags_q  <= flags_d;
            result_q <= result_d;
            done_q   <= done_d;
            ptr0_q   <= ptr0_d;
            ptr1_q   <= ptr1_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave: ready pulses one cycle after both write channels are valid
    always_comb begin
        awrdy_d  = s_axi_awvalid && s_axi_wvalid && !awrdy_q && !bvalid_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (awrdy_q) begin
            bvalid_d = 1'b1;
            bresp_d  = (s_axi_awaddr == asf_pkg::OFS_FLAG
                        || s_axi_awaddr == asf_pkg::OFS_RESULT)
                       ? asf_pkg::RESP_OKAY : asf_pkg::RESP_SLVERR;
        end
        arrdy_d  = s_axi_arvalid && !arrdy_q && !rvalid_q;
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (arrdy_q) begin
            rvalid_d = 1'b1;
            rresp_d  = asf_pkg::RESP_OKAY;
            case (s_axi_araddr)
                asf_pkg::OFS_FLAG:   rdata_d = {24'h00_0000, flags_q};
                asf_pkg::OFS_RESULT: rdata_d = {24'h00_0000, result_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = asf_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            awrdy_q  <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= asf_pkg::RESP_OKAY;
            arrdy_q  <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= asf_pkg::RESP_OKAY;
        end else begin
            awrdy_q  <= awrdy_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
            arrdy_q  <= arrdy_d;
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    // outputs straight from flops
    assign rsp.done        = done_q;
    assign rsp.result      = result_q;
    assign rsp.flags       = flags_q;
    assign rsp.ptr0Step    = ptr0_q;
    assign rsp.ptr1Step    = ptr1_q;
    assign s_axi_awready   = awrdy_q;
    assign s_axi_wready    = awrdy_q;
    assign s_axi_bvalid    = bvalid_q;
    assign s_axi_bresp     = bresp_q;
    assign s_axi_arready   = arrdy_q;
    assign s_axi_rvalid    = rvalid_q;
    assign s_axi_rdata     = rdata_q;
    assign s_axi_rresp     = rresp_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_clr_pattern: assert property (
        req.valid && req.op == asf_pkg::OP_CLR && req.destFlag && !busWr
        |=> flags_q == {4'h0, $past(flags_q[3]), 1'b1, $past(flags_q[1:0])})
        else $error("clear of flag register gave wrong pattern");

    chk_zero_flag: assert property (
        req.valid && req.op == asf_pkg::OP_XOR && !req.destFlag && !busWr
        |=> flags_q[asf_pkg::BIT_ZERO] == (result_q == 8'h00))
        else $error("zero flag does not match result");

    chk_flags_kept: assert property (
        req.valid && !req.destFlag && !busWr && (req.op == asf_pkg::OP_SWAP
        || req.op == asf_pkg::OP_MOV || req.op == asf_pkg::OP_BCLR
        || req.op == asf_pkg::OP_BSET)
        |=> $stable(flags_q))
        else $error("flag changed by a flag-neutral op");

    chk_add_imm: assert property (
        req.valid && req.op == asf_pkg::OP_ADD && req.src == asf_pkg::SRC_IMM
        && !req.destFlag && !busWr
        |=> ({flags_q[asf_pkg::BIT_CARRY], result_q}
            == {1'b0, $past(req.acc)} + {1'b0, $past(req.imm)})
        ##1 (!rsp.done || $past(req.valid)))
        else $error("immediate add result or carry wrong");

    chk_sub_borrow: assert property (
        req.valid && req.op == asf_pkg::OP_SUB && req.src == asf_pkg::SRC_FILE
        && !req.destFlag && !busWr
        |=> flags_q[asf_pkg::BIT_CARRY] == ($past(req.file) >= $past(req.acc))
            && result_q == $past(req.file) - $past(req.acc))
        else $error("subtract borrow polarity wrong");

    chk_signed_range: assert property (
        req.valid && req.op == asf_pkg::OP_ADD && !req.destFlag && !busWr
        |=> flags_q[asf_pkg::BIT_SIGNED]
            == (($signed($past(req.acc)) + $signed($past(opnd))) > 127
             || ($signed($past(req.acc)) + $signed($past(opnd))) < -128))
        else $error("signed range flag wrong");

    chk_nibble_carry: assert property (
        req.valid && req.op == asf_pkg::OP_ADD && !req.destFlag && !busWr
        |=> flags_q[asf_pkg::BIT_NIBBLE]
            == ({1'b0, $past(req.acc[3:0])} + {1'b0, $past(opnd[3:0])} > 5'h0f))
        else $error("nibble carry wrong");

    chk_step_mode: assert property (
        ##1 rsp.ptr0Step == (flags_q[5] ? asf_pkg::STEP_HOLD
            : (flags_q[4] ? asf_pkg::STEP_INC : asf_pkg::STEP_DEC)))
        else $error("pointer zero step mode mismatch");

    chk_rotate_carry: assert property (
        req.valid && req.op == asf_pkg::OP_RRC && req.src == asf_pkg::SRC_ACC
        && !req.destFlag && !busWr
        |=> flags_q[asf_pkg::BIT_CARRY] == $past(req.acc[0])
            && result_q == {$past(flags_q[0]), $past(req.acc[7:1])})
        else $error("rotate right carry wrong");

    chk_flag_store: assert property (
        req.valid && req.op == asf_pkg::OP_MOV && req.destFlag && !busWr
        |=> flags_q == $past(req.acc))
        else $error("store to flag register lost");

endmodule

`default_nettype wire

// [verification/asf_decoder_model.sv]
`timescale 1ns/10ps
`default_nettype none

// decoder stand-in: presents instructions to the alu one edge at a time
module asf_decoder_model (
    input  wire logic          clk, // core clock
    output var asf_pkg::asf_req_t req // instruction to the alu
);
    asf_pkg::asf_req_t idleReq;

    ////////////////////////////////////////
    // drive one instruction; returns at the edge that takes it
    task automatic exec(input asf_pkg::asf_req_t r);
        req <= r;
        @(posedge clk);
    endtask

    // drop valid; operand fields turn over so stale values cannot pass
    task automatic idle();
        idleReq = ~req;
        idleReq.valid = 1'b0;
        req <= idleReq;
        @(posedge clk);
    endtask

    // port idle from time zero
    initial begin
        req = '0;
    end
endmodule
`default_nettype wire

// [verification/asf_alu_status_flag_logic_test.sv]
`timescale 1ns/10ps
`default_nettype none

// count one comparison, report a mismatch
`define CHK(nm, ex, got) begin \
    testsRun++; \
    if ((got) !== (ex)) begin \
        failCount++; \
        $display("BAD %s exp %h got %h", nm, ex, got); \
    end \
end
// bounded wait, one look per rising edge
`define WAIT(cond) begin \
    n = 0; \
    do begin @(posedge clk); n++; end while (!(cond) && n < 50); \
    if (!(cond)) begin failCount++; finalReport(); end \
end

module asf_alu_status_flag_logic_test;
    logic              clk;
    logic              resetn;
    asf_pkg::asf_req_t req;
    asf_pkg::asf_rsp_t rsp;
    logic [31:0]       s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready;
    logic [7:0]        expF;          // expected flag register
    logic [7:0]        expR;          // expected last result
    int                failCount = 0;
    int                testsRun = 0;

    ////////////////////////////////////////
    // design and decoder stand-in
    asf_alu_status_flag_logic DUT (
        .clk(clk), .resetn(resetn), .req(req), .rsp(rsp),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );
    asf_decoder_model mdl (.clk(clk), .req(req));

    ////////////////////////////////////////
    // verdict and end of run
    task automatic finalReport();
        if (failCount == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // pointer step action from a mode field
    function automatic asf_pkg::asf_step_t stepOf(input logic [1:0] m);
        return m[1] ? asf_pkg::STEP_HOLD : (m[0] ? asf_pkg::STEP_INC : asf_pkg::STEP_DEC);
    endfunction

    // expected {result, flags} of one instruction
    function automatic logic [15:0] predict(input asf_pkg::asf_req_t r, input logic [7:0] f);
        logic [7:0] b, x, y, res, nf;
        logic [8:0] s;
        logic [4:0] h;
        logic       cin, ar, lg, rot;
        b = (r.src == asf_pkg::SRC_ACC) ? r.acc : (r.src == asf_pkg::SRC_FILE) ? r.file : r.imm;
        x = b;
        y = r.acc;
        cin = 1'b0;
        ar = 1'b1;
        case (r.op)
            asf_pkg::OP_ADD: ;
            asf_pkg::OP_ADDC: cin = f[0];
            asf_pkg::OP_SUB: begin y = ~r.acc; cin = 1'b1; end
            asf_pkg::OP_SUBB: begin y = ~r.acc; cin = f[0]; end
            asf_pkg::OP_INC: begin y = 8'h00; cin = 1'b1; end
            asf_pkg::OP_DEC: y = 8'hff;
            default: ar = 1'b0;
        endcase
        s = x + y + cin;
        h = x[3:0] + y[3:0] + cin;
        lg = r.op inside {asf_pkg::OP_AND, asf_pkg::OP_IOR, asf_pkg::OP_XOR, asf_pkg::OP_COM,
                          asf_pkg::OP_CLR};
        rot = r.op inside {asf_pkg::OP_RRC, asf_pkg::OP_RLC};
        case (r.op)
            asf_pkg::OP_AND: res = r.acc & b;
            asf_pkg::OP_IOR: res = r.acc | b;
            asf_pkg::OP_XOR: res = r.acc ^ b;
            asf_pkg::OP_COM: res = ~b;
            asf_pkg::OP_CLR: res = 8'h00;
            asf_pkg::OP_RRC: res = {f[0], b[7:1]};
            asf_pkg::OP_RLC: res = {b[6:0], f[0]};
            asf_pkg::OP_SWAP: res = {b[3:0], b[7:4]};
            asf_pkg::OP_MOV: res = r.acc;
            asf_pkg::OP_BCLR: res = b & ~(8'h01 << r.bitSel);
            asf_pkg::OP_BSET: res = b | (8'h01 << r.bitSel);
            default: res = s[7:0];
        endcase
        nf = f;
        if (r.destFlag) nf = {res[7:4], (ar | lg | rot) ? f[3:0] : res[3:0]};
        if (ar) nf[3:0] = {x[7] == y[7] && s[7] != x[7], s[7:0] == 8'h00, h[4], s[8]};
        if (lg) nf[2] = (res == 8'h00);
        if (rot) nf[0] = (r.op == asf_pkg::OP_RRC) ? b[0] : b[7];
        return {res, nf};
    endfunction

    ////////////////////////////////////////
    // one instruction, back to back with the next unless idled
    task automatic run(input asf_pkg::asf_op_t op, input asf_pkg::asf_src_t src,
                       input logic [7:0] a, input logic [7:0] fv, input logic [7:0] im,
                       input logic [2:0] bs, input logic df);
        asf_pkg::asf_req_t r;
        logic [15:0]       e;
        r = '{1'b1, op, src, a, fv, im, bs, df};
        e = predict(r, expF);
        expF = e[7:0];
        expR = e[15:8];
        mdl.exec(r);
        #1;
        `CHK("done", 1'b1, rsp.done)
        `CHK("result", expR, rsp.result)
        `CHK("flags", expF, rsp.flags)
        `CHK("ptr0Step", stepOf(expF[5:4]), rsp.ptr0Step)
        `CHK("ptr1Step", stepOf(expF[7:6]), rsp.ptr1Step)
    endtask

    // idle the port and see the done pulse end
    task automatic pause();
        mdl.idle();
        #1;
        `CHK("doneLow", 1'b0, rsp.done)
    endtask

    // bus write, both channels offered together
    task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, input logic [3:0] st,
                            input logic [1:0] er);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        `WAIT(s_axi_awready === 1'b1 && s_axi_wready === 1'b1)
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        `WAIT(s_axi_bvalid === 1'b1)
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask

    // bus read with expected data and response
    task automatic axiRead(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        `WAIT(s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
        `WAIT(s_axi_rvalid === 1'b1)
        s_axi_rready <= 1'b0;
        `CHK("rresp", er, s_axi_rresp)
        `CHK("rdata", ed, s_axi_rdata)
    endtask

    ////////////////////////////////////////
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // main sequence
    initial begin
        resetn = 1'b0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        expF = asf_pkg::FLAG_RESET;
        expR = 8'h00;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        axiRead(asf_pkg::OFS_FLAG, 32'h0000_00f0, asf_pkg::RESP_OKAY);
        run(asf_pkg::OP_ADD, asf_pkg::SRC_IMM, 8'h01, 8'h00, 8'h02, 3'h0, 1'b0);
        run(asf_pkg::OP_ADD, asf_pkg::SRC_FILE, 8'h80, 8'h80, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_ADD, asf_pkg::SRC_IMM, 8'h0f, 8'h00, 8'h01, 3'h0, 1'b0);
        run(asf_pkg::OP_ADD, asf_pkg::SRC_IMM, 8'h7f, 8'h00, 8'h01, 3'h0, 1'b0);
        run(asf_pkg::OP_SUB, asf_pkg::SRC_FILE, 8'h03, 8'h05, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_SUB, asf_pkg::SRC_FILE, 8'h05, 8'h03, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_SUB, asf_pkg::SRC_IMM, 8'h01, 8'h00, 8'h80, 3'h0, 1'b0);
        run(asf_pkg::OP_SUBB, asf_pkg::SRC_IMM, 8'h01, 8'h00, 8'h05, 3'h0, 1'b0);
        run(asf_pkg::OP_ADDC, asf_pkg::SRC_IMM, 8'hff, 8'h00, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_INC, asf_pkg::SRC_FILE, 8'h00, 8'hff, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_DEC, asf_pkg::SRC_ACC, 8'h00, 8'h11, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_DEC, asf_pkg::SRC_FILE, 8'h00, 8'h80, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_AND, asf_pkg::SRC_IMM, 8'hf0, 8'h00, 8'h0f, 3'h0, 1'b0);
        run(asf_pkg::OP_IOR, asf_pkg::SRC_FILE, 8'h21, 8'h84, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_XOR, asf_pkg::SRC_IMM, 8'h5a, 8'h00, 8'h5a, 3'h0, 1'b0);
        run(asf_pkg::OP_COM, asf_pkg::SRC_ACC, 8'hff, 8'h00, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_RRC, asf_pkg::SRC_FILE, 8'h00, 8'h01, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_RLC, asf_pkg::SRC_FILE, 8'h00, 8'h80, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_SWAP, asf_pkg::SRC_FILE, 8'h00, 8'ha5, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_MOV, asf_pkg::SRC_FILE, 8'h00, 8'h33, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_BCLR, asf_pkg::SRC_FILE, 8'h00, 8'h80, 8'h00, 3'h7, 1'b0);
        run(asf_pkg::OP_BSET, asf_pkg::SRC_FILE, 8'h00, 8'h00, 8'h00, 3'h0, 1'b0);
        run(asf_pkg::OP_BSET, asf_pkg::SRC_FILE, 8'h00, expF, 8'h00, 3'h4, 1'b1);
        run(asf_pkg::OP_CLR, asf_pkg::SRC_FILE, 8'h00, expF, 8'h00, 3'h0, 1'b1);
        run(asf_pkg::OP_ADD, asf_pkg::SRC_IMM, 8'h30, 8'h00, 8'h50, 3'h0, 1'b1);
        run(asf_pkg::OP_MOV, asf_pkg::SRC_ACC, 8'h5a, 8'h00, 8'h00, 3'h0, 1'b1);
        pause();
        axiWrite(asf_pkg::OFS_FLAG, 32'hffff_ff2c, 4'hf, asf_pkg::RESP_OKAY);
        expF = 8'h2c;
        axiRead(asf_pkg::OFS_FLAG, 32'h0000_002c, asf_pkg::RESP_OKAY);
        axiWrite(asf_pkg::OFS_FLAG, 32'h0000_0011, 4'h0, asf_pkg::RESP_OKAY);
        axiWrite(asf_pkg::OFS_RESULT, 32'h0000_0055, 4'hf, asf_pkg::RESP_OKAY);
        axiRead(asf_pkg::OFS_RESULT, {24'h0, expR}, asf_pkg::RESP_OKAY);
        axiWrite(32'h0000_0008, 32'h0000_00ff, 4'hf, asf_pkg::RESP_SLVERR);
        axiRead(32'h0000_0008, 32'h0000_0000, asf_pkg::RESP_SLVERR);
        `CHK("busFlags", expF, rsp.flags)
        run(asf_pkg::OP_ADDC, asf_pkg::SRC_IMM, 8'h01, 8'h00, 8'h01, 3'h0, 1'b0);
        pause();
        // reset in mid-run returns the flag register to its reset value
        resetn <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("rstFlags", asf_pkg::FLAG_RESET, rsp.flags)
        resetn <= 1'b1;
        expF = asf_pkg::FLAG_RESET;
        @(posedge clk);
        run(asf_pkg::OP_SUB, asf_pkg::SRC_IMM, 8'h10, 8'h00, 8'h10, 3'h0, 1'b0);
        pause();
        finalReport();
    end
endmodule
`default_nettype wire
